// File: shared/wrc_pkg.sv
// Package for the watchdog, periodic interrupt and clock monitor block.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz aclk.
package wrc_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [5:0] IDX_RTI_CONTROL = 6'h14;
	localparam logic [5:0] IDX_RTI_FLAG = 6'h15;
	localparam logic [5:0] IDX_WATCHDOG_CONTROL = 6'h16;
	localparam logic [5:0] IDX_WATCHDOG_SERVICE = 6'h17;
	localparam logic [5:0] IDX_MONITOR_LIMIT = 6'h18;
	localparam logic [5:0] IDX_STATUS = 6'h19;
	// Service key values
	localparam logic [7:0] KEY_ARM = 8'h55;
	localparam logic [7:0] KEY_RESTART = 8'haa;
	// Flag register bit
	localparam int FLAG_BIT = 7;
	// Prescaler: normal divide 2^13, bypassed divide 4
	localparam int PRE_W = 13;
	localparam logic [PRE_W-1:0] PRE_LAST = 13'h1fff;
	localparam logic [1:0] PRE_BYP_LAST = 2'h3;
	// Lowest watchdog exponent above the prescaler
	localparam int WD_EXP_BASE = 13;
	localparam int WD_CNT_W = 11;
	localparam int RTI_CNT_W = 7;
	// Reset values
	localparam logic [2:0] WD_RATE_RST = 3'h7;
	localparam logic [2:0] RATE_OFF = 3'h0;
	// Monitor time-out range in ns, clock period in ns
	localparam int CLK_PERIOD_NS = 100;
	localparam int MON_MIN_NS = 2000;
	localparam int MON_MAX_NS = 20000;
	localparam int MON_MIN_CYC = (MON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MON_MAX_CYC = MON_MAX_NS / CLK_PERIOD_NS;
	localparam int MON_W = 8;
	localparam logic [MON_W-1:0] MON_LIMIT_RST = MON_W'(MON_MAX_CYC);
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Periodic interrupt control layout, bit 7 down to bit 0
	typedef struct packed {
		logic periodic_irq_enable;
		logic wait_stop_bit;
		logic debug_stop_bit;
		logic reserved;
		logic prescaler_bypass;
		logic [2:0] rate;
	} wrc_rti_control_t;

	// Watchdog control layout, bit 7 down to bit 0
	typedef struct packed {
		logic monitor_enable;
		logic force_monitor;
		logic force_failure_reset;
		logic windowed_watchdog;
		logic reset_disable;
		logic [2:0] rate;
	} wrc_wdctl_t;
endpackage

// File: src/wrc_clock_monitor.sv
// Clock monitor: a delay counter on aclk reloaded by reference edges.
// Assumes the reference level is already synchronous to aclk.
`timescale 1ns/100ps
module wrc_clock_monitor #(
	parameter int LIMIT_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic active,
	input wire logic [LIMIT_W-1:0] limit,
	// Reference level
	input wire logic reference_oscillator_clock,
	// Time-out pulse
	output logic fail_q
);
	logic ref_q; // Previous reference level
	logic [LIMIT_W-1:0] cnt_q; // Cycles since last edge
	logic [LIMIT_W-1:0] cnt_d;
	logic fail_d;
	wire edge_seen = ref_q ^ reference_oscillator_clock;
	wire expired = (cnt_q >= limit);

	// Reload on every edge, restart after a failure so it repeats
	assign cnt_d = (!active || edge_seen || expired) ? '0 : cnt_q + 1'b1;
	assign fail_d = active && !edge_seen && expired;

	// Counter and edge history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_q <= 1'b0;
			cnt_q <= '0;
			fail_q <= 1'b0;
		end else begin
			ref_q <= reference_oscillator_clock;
			cnt_q <= cnt_d;
			fail_q <= fail_d;
		end
	end
endmodule

// File: src/wrc_top.sv
// Watchdog, periodic interrupt and clock monitor with an AXI4-Lite slave.
// Assumes timer_clock is a one-cycle tick synchronous to aclk.
//
// Notes on behaviour
// - Any other service value resets at once while the watchdog rate is non-zero
// - Three-bit rate, seven periods, zero is off
// - Windowed mode: service only in last quarter
// - Periodic flag at seven rates, own enable
// - Monitor resets when reference stops 2-20us
// - Request asserted while flag and enable set
// - Wait-stop halts counters in wait mode
// - Debug-stop halts counters in debug mode
// - Special-mode bypass divides timer clock by four
// - Periodic divisors 2^13 to 2^19
// - Flag set on period, write-one clears
// - Monitor enable allows reset or limp-home
// - Force bit overrides monitor enable
// - Monitor enable resets per loop supply; with EARLY_SILICON set it resets to 0
// - Force bit write-once in normal modes, writable any time in special
// - Watchdog divisors 2^13..2^23, zero disables
// - Reset-disable blocks both resets, special only
// - Restart key after the arm key restarts; service reads zero
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module wrc_top #(
	parameter int ADDR_W = 8,
	parameter bit EARLY_SILICON = 1'b0,
	parameter int MON_LIMIT_W = wrc_pkg::MON_W
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Chip mode and clock inputs
	input wire logic special_mode,
	input wire logic wait_mode,
	input wire logic debug_mode,
	input wire logic loop_supply,
	input wire logic limp_home_allowed,
	input wire logic timer_clock,
	input wire logic reference_oscillator_clock,
	// Requests to the system
	output logic periodic_irq,
	output logic watchdog_reset_q,
	output logic monitor_reset_q,
	output logic limp_home_req_q
);
	// Parameter sanity
	if (ADDR_W < 8) begin : g_chk_addr
		$error("ADDR_W must reach the register indices");
	end
	if (MON_LIMIT_W < 8) begin : g_chk_mon
		$error("MON_LIMIT_W too narrow for the monitor range");
	end

	// Watchdog divide exponent above the prescaler, as a period in ticks
	function automatic logic [wrc_pkg::WD_CNT_W-1:0] wd_len(input logic [2:0] rate);
		logic [wrc_pkg::WD_CNT_W-1:0] one;
		one = wrc_pkg::WD_CNT_W'(1);
		unique case (rate)
			3'h1: wd_len = one << 0;
			3'h2: wd_len = one << 2;
			3'h3: wd_len = one << 4;
			3'h4: wd_len = one << 6;
			3'h5: wd_len = one << 8;
			3'h6: wd_len = one << 9;
			3'h7: wd_len = one << 10;
			3'h0: wd_len = '0;
		endcase
	endfunction

	// Periodic period in prescaler ticks: 2^(rate-1)
	function automatic logic [wrc_pkg::RTI_CNT_W-1:0] rti_len(input logic [2:0] rate);
		rti_len = (rate == wrc_pkg::RATE_OFF) ? '0 : wrc_pkg::RTI_CNT_W'(1) << (rate - 3'h1);
	endfunction

	// Register index of a byte address
	function automatic logic [5:0] reg_idx(input logic [ADDR_W-1:0] a);
		reg_idx = a[7:2];
	endfunction

	// Control registers
	wrc_pkg::wrc_rti_control_t rti_control_q;
	wrc_pkg::wrc_wdctl_t wdctl_q;
	logic flag_q; // Periodic flag
	logic [MON_LIMIT_W-1:0] mon_limit_q; // Monitor terminal count
	// Write-once tracking for normal modes
	logic once_wait_q;
	logic once_debug_q;
	logic once_force_q;
	logic once_window_q;
	logic once_rate_q;
	logic init_q; // Reset values caught after release
	// Timing chain
	logic [wrc_pkg::PRE_W-1:0] pre_q;
	logic [wrc_pkg::RTI_CNT_W-1:0] rti_cnt_q;
	logic [wrc_pkg::WD_CNT_W-1:0] wd_cnt_q;
	logic armed_q; // Arm key seen
	// Bus state
	logic aw_held_q;
	logic w_held_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	// Counting halts in wait or debug when asked
	wire halted = (wait_mode && rti_control_q.wait_stop_bit)
		|| (debug_mode && rti_control_q.debug_stop_bit);
	wire run = timer_clock && !halted;
	// Prescaler end, bypass shortens it to four
	wire pre_end = rti_control_q.prescaler_bypass ? (pre_q[1:0] == wrc_pkg::PRE_BYP_LAST)
		: (pre_q == wrc_pkg::PRE_LAST);
	wire pre_tick = run && pre_end;

	// Periodic interrupt
	wire [wrc_pkg::RTI_CNT_W-1:0] rti_period = rti_len(rti_control_q.rate);
	wire rti_on = (rti_control_q.rate != wrc_pkg::RATE_OFF);
	wire rti_end = rti_on && pre_tick && (rti_cnt_q == rti_period - 1'b1);
	assign periodic_irq = flag_q && rti_control_q.periodic_irq_enable;

	// Watchdog period and window
	wire [wrc_pkg::WD_CNT_W-1:0] wd_period = wd_len(wdctl_q.rate);
	wire wd_on = (wdctl_q.rate != wrc_pkg::RATE_OFF);
	wire wd_expire = wd_on && pre_tick && (wd_cnt_q == wd_period - 1'b1);
	// Last quarter; too short periods never open
	wire window_open = (wd_period[wrc_pkg::WD_CNT_W-1:2] != '0)
		&& (wd_cnt_q >= wd_period - (wd_period >> 2));

	// Bus decode
	wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
	wire [5:0] w_idx = reg_idx(awaddr_q);
	wire w_lane = wstrb_q[0];
	wire [7:0] w_byte = wdata_q[7:0];
	wire w_mapped = (w_idx >= wrc_pkg::IDX_RTI_CONTROL) && (w_idx <= wrc_pkg::IDX_STATUS);
	wire wr_rti_control = do_write && w_lane && (w_idx == wrc_pkg::IDX_RTI_CONTROL);
	wire wr_flag = do_write && w_lane && (w_idx == wrc_pkg::IDX_RTI_FLAG);
	wire wr_wdctl = do_write && w_lane && (w_idx == wrc_pkg::IDX_WATCHDOG_CONTROL);
	wire wr_service = do_write && w_lane && (w_idx == wrc_pkg::IDX_WATCHDOG_SERVICE);
	wire wr_limit = do_write && w_lane && (w_idx == wrc_pkg::IDX_MONITOR_LIMIT);

	// Service write outcomes
	wire svc_arm = wr_service && (w_byte == wrc_pkg::KEY_ARM);
	wire svc_restart = wr_service && (w_byte == wrc_pkg::KEY_RESTART);
	wire svc_bad = wr_service && !svc_arm && !svc_restart;
	wire svc_early = (svc_arm || svc_restart) && wdctl_q.windowed_watchdog && !window_open;
	wire svc_ok_restart = svc_restart && armed_q && !svc_early;
	wire svc_ok_arm = svc_arm && !svc_early;

	// Clock monitor, force bit overrides enable
	wire mon_active = wdctl_q.force_monitor || wdctl_q.monitor_enable;
	wire mon_fail;
	wrc_clock_monitor #(
		.LIMIT_W(MON_LIMIT_W)
	) u_monitor (
		.aclk(aclk),
		.aresetn(aresetn),
		.active(mon_active),
		.limit(mon_limit_q),
		.reference_oscillator_clock(reference_oscillator_clock),
		.fail_q(mon_fail)
	);

	// Forced failures in special modes
	wire force_wd = wdctl_q.force_failure_reset && wd_on;
	wire force_mon = wdctl_q.force_failure_reset && mon_active;
	// Failure causes, before reset-disable
	wire wd_fail = wd_on && (wd_expire || svc_bad || svc_early) || force_wd;
	wire mon_event = mon_fail || force_mon;
	wire limp = mon_fail && limp_home_allowed;
	wire resets_ok = !wdctl_q.reset_disable;

	// Monitor limit clamped into the legal range
	wire [MON_LIMIT_W-1:0] lim_min = MON_LIMIT_W'(wrc_pkg::MON_MIN_CYC);
	wire [MON_LIMIT_W-1:0] lim_max = MON_LIMIT_W'(wrc_pkg::MON_MAX_CYC);
	wire [MON_LIMIT_W-1:0] lim_in = MON_LIMIT_W'(w_byte);
	wire [MON_LIMIT_W-1:0] lim_clamped = (lim_in < lim_min) ? lim_min
		: (lim_in > lim_max) ? lim_max : lim_in;

	// Write permission: once in normal modes, any time in special
	wire ok_wait = special_mode || !once_wait_q;
	wire ok_debug = special_mode || !once_debug_q;
	wire ok_force = special_mode || !once_force_q;
	wire ok_window = special_mode || !once_window_q;
	wire ok_rate = special_mode || !once_rate_q;

	// Reset values of the watchdog control, strapped from mode and supply
	wire mon_rst = loop_supply && !EARLY_SILICON;

	// Status view
	wire [7:0] status = {4'h0, halted, mon_active, window_open, armed_q};

	// Read data mux
	wire [5:0] r_idx = reg_idx(s_axi_araddr);
	wire r_mapped = (r_idx >= wrc_pkg::IDX_RTI_CONTROL) && (r_idx <= wrc_pkg::IDX_STATUS);
	logic [7:0] r_byte;
	always_comb begin
		r_byte = 8'h00;
		unique case (r_idx)
			wrc_pkg::IDX_RTI_CONTROL: r_byte = rti_control_q;
			wrc_pkg::IDX_RTI_FLAG: r_byte = {flag_q, 7'h00};
			wrc_pkg::IDX_WATCHDOG_CONTROL: r_byte = wdctl_q;
			wrc_pkg::IDX_MONITOR_LIMIT: r_byte = mon_limit_q[7:0];
			wrc_pkg::IDX_STATUS: r_byte = status;
			default: r_byte = 8'h00; // Service register reads zero too
		endcase
	end

	// Handshake outputs
	assign s_axi_awready = !aw_held_q;
	assign s_axi_wready = !w_held_q;
	assign s_axi_arready = !s_axi_rvalid;

	// Write channel holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= wrc_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= w_mapped ? wrc_pkg::RESP_OKAY : wrc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read response, one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= wrc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, r_byte};
			s_axi_rresp <= r_mapped ? wrc_pkg::RESP_OKAY : wrc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Periodic control; first cycle after reset is quiet
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rti_control_q <= '0;
			once_wait_q <= 1'b0;
			once_debug_q <= 1'b0;
		end else if (wr_rti_control) begin
			rti_control_q.periodic_irq_enable <= w_byte[7];
			rti_control_q.rate <= w_byte[2:0];
			if (ok_wait) begin
				rti_control_q.wait_stop_bit <= w_byte[6];
				once_wait_q <= 1'b1;
			end
			if (ok_debug) begin
				rti_control_q.debug_stop_bit <= w_byte[5];
				once_debug_q <= 1'b1;
			end
			if (special_mode) begin
				rti_control_q.prescaler_bypass <= w_byte[3];
			end
		end
	end

	// Periodic flag: a new period beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0;
		end else if (rti_end) begin
			flag_q <= 1'b1;
		end else if (wr_flag && w_byte[wrc_pkg::FLAG_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	// Watchdog control; mode and supply straps caught one cycle after release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdctl_q <= '0;
			init_q <= 1'b1;
			once_force_q <= 1'b0;
			once_window_q <= 1'b0;
			once_rate_q <= 1'b0;
		end else if (init_q) begin
			init_q <= 1'b0;
			wdctl_q.monitor_enable <= mon_rst;
			wdctl_q.reset_disable <= special_mode;
			wdctl_q.rate <= wrc_pkg::WD_RATE_RST;
		end else if (wr_wdctl) begin
			wdctl_q.monitor_enable <= w_byte[7];
			if (ok_force) begin
				wdctl_q.force_monitor <= w_byte[6];
				once_force_q <= 1'b1;
			end
			if (ok_window) begin
				wdctl_q.windowed_watchdog <= w_byte[4];
				once_window_q <= 1'b1;
			end
			if (ok_rate) begin
				wdctl_q.rate <= w_byte[2:0];
				once_rate_q <= 1'b1;
			end
			if (special_mode) begin
				wdctl_q.force_failure_reset <= w_byte[5];
				wdctl_q.reset_disable <= w_byte[3];
			end
		end
	end

	// Monitor terminal count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mon_limit_q <= MON_LIMIT_W'(wrc_pkg::MON_LIMIT_RST);
		end else if (wr_limit) begin
			mon_limit_q <= lim_clamped;
		end
	end

	// Prescaler; never cleared by a watchdog restart
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q <= '0;
		end else if (run) begin
			pre_q <= pre_end ? '0 : pre_q + 1'b1;
		end
	end

	// Periodic counter
	always_ff @(posedge aclk) begin
		if (!aresetn || !rti_on) begin
			rti_cnt_q <= '0;
		end else if (pre_tick) begin
			rti_cnt_q <= rti_end ? '0 : rti_cnt_q + 1'b1;
		end
	end

	// Watchdog counter and key sequence
	always_ff @(posedge aclk) begin
		if (!aresetn || !wd_on) begin
			wd_cnt_q <= '0;
			armed_q <= 1'b0;
		end else if (svc_ok_restart || wd_expire) begin
			wd_cnt_q <= '0;
			armed_q <= 1'b0;
		end else begin
			if (pre_tick) begin
				wd_cnt_q <= wd_cnt_q + 1'b1;
			end
			if (svc_ok_arm) begin
				armed_q <= 1'b1;
			end
		end
	end

	// Reset and limp-home requests, one-cycle pulses unless a failure is forced
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_reset_q <= 1'b0;
			monitor_reset_q <= 1'b0;
			limp_home_req_q <= 1'b0;
		end else begin
			watchdog_reset_q <= wd_fail && resets_ok;
			monitor_reset_q <= mon_event && !limp && resets_ok;
			limp_home_req_q <= limp;
		end
	end
endmodule

// File: verif/wrc_props.sv
// Checker: bus handshakes and request outputs of the supervisory block.
// Assumes it is bound to wrc_top and sees only that module's ports.
`timescale 1ns/100ps
module wrc_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Requests and their qualifiers
	input wire logic limp_home_allowed,
	input wire logic periodic_irq,
	input wire logic watchdog_reset_q,
	input wire logic limp_home_req_q
);
	// One domain, so one clock and one disable for all
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_rst_quiet: assert property ($rose(aresetn) |-> !periodic_irq && !watchdog_reset_q)
		else $error("request active right after reset");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	// A held write may not execute while a response still stands
	a_wr_block: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("new write executed before response");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_irq_drop: assert property ($fell(periodic_irq) |-> s_axi_bvalid)
		else $error("interrupt dropped without a write");
	a_limp_gate: assert property (limp_home_req_q |-> $past(limp_home_allowed))
		else $error("limp-home pulse while not allowed");
endmodule

bind wrc_top wrc_props i_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.limp_home_allowed(limp_home_allowed), .periodic_irq(periodic_irq),
	.watchdog_reset_q(watchdog_reset_q), .limp_home_req_q(limp_home_req_q));

// File: verif/testbench.sv
// Testbench: register bus master, mode pins and reference clock driver.
// Assumes timer_clock ticks every cycle and bypass shortens all periods.
`timescale 1ns/100ps
module testbench;
	localparam logic [5:0] RTC = wrc_pkg::IDX_RTI_CONTROL;
	localparam logic [5:0] RFL = wrc_pkg::IDX_RTI_FLAG;
	localparam logic [5:0] WDC = wrc_pkg::IDX_WATCHDOG_CONTROL;
	localparam logic [5:0] SVC = wrc_pkg::IDX_WATCHDOG_SERVICE;
	localparam logic [1:0] OK = wrc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = wrc_pkg::RESP_SLVERR;
	// Driven inputs, all but v valued at time zero
	logic aclk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic smode = 0, wmode = 0, dmode = 0, lsup = 1, limp_ok = 0, ref_clk = 0, ref_run = 1, irq_l = 0;
	logic [7:0] awa = 0, ara = 0, v;
	logic [31:0] wd = 0;
	// Observed outputs
	wire awr, wrd, bv, arr, rv, irq, wdr, monr, limp;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	int failures = 0, n_compared = 0, n_wd = 0, n_mon = 0, n_limp = 0, n_rise = 0, cyc = 0;
	int t[3];

	wrc_top i_dut (.aclk(aclk), .aresetn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .special_mode(smode),
		.wait_mode(wmode), .debug_mode(dmode), .loop_supply(lsup), .limp_home_allowed(limp_ok),
		.timer_clock(1'b1), .reference_oscillator_clock(ref_clk), .periodic_irq(irq),
		.watchdog_reset_q(wdr), .monitor_reset_q(monr), .limp_home_req_q(limp));

	// 10 MHz clock
	always #50 aclk = ~aclk;
	// Count pulses and interrupt rises away from the edge
	always @(negedge aclk) begin
		cyc++;
		n_wd += int'(wdr);
		n_mon += int'(monr);
		n_limp += int'(limp);
		n_rise += int'(irq && !irq_l);
		irq_l = irq;
	end
	// Random reference edges; a stall beyond the limit is vanishingly rare
	always @(posedge aclk) begin
		if (ref_run && $urandom_range(1) == 1) ref_clk <= ~ref_clk;
	end

	task automatic chk(input bit ok, input string m);
		n_compared++;
		if (!ok) begin
			failures++;
			$display("ERROR %0t: %s", $time, m);
		end
	endtask
	task automatic run(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Write one word; address and data are released as each is taken
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a, w, b;
		int n;
		n = 0;
		b = 0;
		awa <= {idx, 2'h0};
		// Random upper bits, which the registers must ignore
		wd <= {8'($urandom), 16'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		while (!b && n < 50) begin
			@(negedge aclk);
			a = awv && awr;
			w = wv && wrd;
			b = bv;
			if (b) chk(br === er, "write response");
			@(posedge aclk);
			if (a) awv <= 1'b0;
			if (w) wv <= 1'b0;
			n++;
		end
		// Ready stays up between writes, so no second drive in one step
		if (!b) chk(1'b0, "write hung");
	endtask
	// Read one word and compare data and response
	task automatic rd(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
		logic a, t;
		int n;
		n = 0;
		a = 0;
		ara <= {idx, 2'h0};
		arv <= 1'b1;
		rre <= 1'b1;
		while (!a && n < 50) begin
			// Handshake seen away from the edge that takes it
			@(negedge aclk);
			t = arv && arr;
			a = rv;
			if (a) chk(rdat === {24'h0, e} && rr === er, "read value");
			@(posedge aclk);
			if (t) arv <= 1'b0;
			n++;
		end
		if (!a) chk(1'b0, "read hung");
	endtask
	// Wait for a counter to move, bounded
	task automatic wait_up(ref int c, input int lim);
		int s, n;
		s = c;
		n = 0;
		while (c == s && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk(c != s, "event missing");
	endtask
	// Watchdog period in cycles with bypass and a tick every cycle
	function automatic int wd_cyc(input int r);
		return 4 * (r <= 5 ? 1 << (2 * r - 2) : 1 << (r + 3));
	endfunction
	task automatic end_of_test;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog on the run itself
	initial begin
		#5000000;
		failures++;
		end_of_test();
	end

	initial begin
		void'($urandom(35921));
		run(16);
		rstn <= 1'b1;
		run(2);
		rd(WDC, 8'h87, OK);
		rd(SVC, 8'h00, OK);
		wr(RTC, 8'h48, OK);
		wr(RTC, 8'h00, OK);
		rd(RTC, 8'h40, OK);
		wr(6'h02, 8'h5a, ERR);
		rd(6'h3f, 8'h00, ERR);
		smode <= 1'b1;
		// Periodic rates: time between two rises
		for (int r = 2; r < 8; r++) begin
			wr(RTC, 8'h88 | 8'(r), OK);
			for (int k = 0; k < 3; k++) begin
				wr(RFL, 8'h80, OK);
				wait_up(n_rise, 600);
				t[k] = cyc;
			end
			chk(t[2] - t[1] == (4 << (r - 1)), "periodic rate");
		end
		// Enable low: flag sets, no request; write-one clear
		wr(RTC, 8'h0a, OK);
		wr(RFL, 8'h80, OK);
		run(20);
		chk(irq === 1'b0, "request while disabled");
		wr(RFL, 8'h7f, OK);
		rd(RFL, 8'h80, OK);
		// Rate off first, so no new period can set the flag before the read
		wr(RTC, 8'h08, OK);
		wr(RFL, 8'h80, OK);
		rd(RFL, 8'h00, OK);
		// Wait and debug halts
		for (int m = 0; m < 2; m++) begin
			wr(RTC, m == 0 ? 8'hca : 8'haa, OK);
			{wmode, dmode} <= m == 0 ? 2'b10 : 2'b01;
			wr(RFL, 8'h80, OK);
			run(40);
			chk(irq === 1'b0, "counter not halted");
			{wmode, dmode} <= 2'b00;
			wait_up(n_rise, 30);
		end
		// Watchdog time-out per rate
		for (int r = 1; r < 5; r++) begin
			wr(WDC, 8'h00, OK);
			wr(WDC, 8'(r), OK);
			t[0] = cyc;
			wait_up(n_wd, wd_cyc(r) + 12);
			chk(cyc - t[0] >= wd_cyc(r) - 6 && cyc - t[0] <= wd_cyc(r) + 6, "timeout");
		end
		// Key sequence keeps it quiet; bad key and silence do not
		wr(WDC, 8'h00, OK);
		wr(WDC, 8'h03, OK);
		n_wd = 0;
		repeat (4) begin
			run(30);
			wr(SVC, wrc_pkg::KEY_ARM, OK);
			wr(SVC, wrc_pkg::KEY_RESTART, OK);
		end
		chk(n_wd == 0, "serviced watchdog fired");
		do v = 8'($urandom); while (v == 8'h55 || v == 8'haa);
		wr(SVC, v, OK);
		run(2);
		chk(n_wd == 1, "bad key ignored");
		run(80);
		chk(n_wd >= 2, "no timeout");
		// Windowed: early write resets, late sequence accepted
		for (int k = 0; k < 2; k++) begin
			wr(WDC, 8'h00, OK);
			wr(WDC, 8'h13, OK);
			n_wd = 0;
			run(k * 46);
			wr(SVC, wrc_pkg::KEY_ARM, OK);
			wr(SVC, wrc_pkg::KEY_RESTART, OK);
			run(2);
			// Each premature key write is its own reset request
			chk(n_wd == 2 - 2 * k, "window check");
		end
		// Off and reset-disable: nothing fires
		for (int k = 0; k < 2; k++) begin
			wr(WDC, k == 0 ? 8'h00 : 8'h0b, OK);
			n_wd = 0;
			wr(SVC, v, OK);
			run(100);
			chk(n_wd == 0, "watchdog reset unexpected");
		end
		// Monitor with a short limit
		wr(wrc_pkg::IDX_MONITOR_LIMIT, 8'd20, OK);
		for (int k = 0; k < 4; k++) begin
			wr(WDC, k == 1 ? 8'h00 : k == 2 ? 8'h40 : k == 3 ? 8'h88 : 8'h80, OK);
			ref_run <= 1'b0;
			n_mon = 0;
			run(100);
			chk((k % 2 == 0) ? (n_mon == 4 || n_mon == 5) : n_mon == 0, "monitor");
			ref_run <= 1'b1;
			run(5);
		end
		// Monitor on and resets allowed, reference running
		wr(WDC, 8'h80, OK);
		n_mon = 0;
		run(150);
		chk(n_mon == 0, "monitor fired with reference");
		limp_ok <= 1'b1;
		ref_run <= 1'b0;
		n_limp = 0;
		run(5);
		n_mon = 0;
		run(100);
		chk(n_limp >= 4 && n_mon == 0, "limp-home");
		limp_ok <= 1'b0;
		ref_run <= 1'b1;
		// Second reset with loop supply absent
		lsup <= 1'b0;
		rstn <= 1'b0;
		run(16);
		rstn <= 1'b1;
		run(2);
		rd(WDC, 8'h0f, OK);
		end_of_test();
	end
endmodule
